// *** hw/ssf_framer.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Sensor sample with api_output_option zero emits frame type 0x94 at offset 3.
// - Sender 64-bit address fills bytes 4 to 11, most significant first.
// - Sender 16-bit network address fills bytes 12 and 13, high first.
// - Byte 14 receive options: 0x01 acknowledged, 0x02 broadcast.
// - Byte 15 ORs 0x01 A/D read, 0x02 temperature, 0x60 water pin low.
// - Bytes 16 to 23 carry A/D readings A, B, C, D, high first.
// - Bytes 24 and 25 carry thermometer reading, 0xFFFF when none found.
// - Node identification frame 0x95 sent when api_output_option is zero.
// - I/O samples forwarded as frame 0x92 only in API mode with api_output_option zero.
// - Digital sample bits of lines not enabled read zero, matching mask.
// - Each enabled analog input adds two bytes, channel 0 up to 3.
module ssf_framer
	import ssf_pkg::*;
#(
	// Arbitrary neutral identity values
	parameter logic [15:0] PROFILE_ID = 16'h0001,
	parameter logic [15:0] MAKER_ID   = 16'h0001
) (
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	input  wire logic [1:0]     api_output_option_in,
	input  wire logic           api_mode_in,
	input  wire logic           water_detect_pin_in,
	input  wire logic           sensor_valid_in,
	input  wire ssf_sensor_type sensor_in,
	input  wire logic           io_valid_in,
	input  wire ssf_io_type     io_in,
	input  wire logic           node_valid_in,
	input  wire ssf_node_type   node_in,
	output logic                req_ready_out,
	output logic                drop_out,
	output logic [7:0]          byte_out,
	output logic                byte_valid_out,
	input  wire logic           byte_ready_in
);

	ssf_ctl_type s;
	ssf_ctl_type next_s;
	logic        stage_free;
	logic        stage_load;
	logic [7:0]  stage_byte;

	function automatic ssf_buf_type put8(input ssf_buf_type b, input int off, input logic [7:0] v);
		ssf_buf_type r;
		r = b;
		r[off - SSF_OFF_TYPE] = v;
		return r;
	endfunction

	function automatic ssf_buf_type put16(input ssf_buf_type b, input int off, input logic [15:0] v);
		ssf_buf_type r;
		r = put8(b, off, v[15:8]);
		r = put8(r, off + 1, v[7:0]);
		return r;
	endfunction

	function automatic ssf_buf_type put64(input ssf_buf_type b, input int off, input logic [63:0] v);
		ssf_buf_type r;
		r = b;
		for (int k = 0; k < 8; k++) begin
			r = put8(r, off + k, v[63 - 8*k -: 8]);
		end
		return r;
	endfunction

	function automatic ssf_buf_type put_origin(input ssf_buf_type b, input logic [7:0] ftype,
	                                           input ssf_origin_type o);
		ssf_buf_type r;
		logic [7:0]  opt;
		opt = (o.ack ? SSF_RX_ACK : 8'h00) | (o.bcast ? SSF_RX_BCAST : 8'h00);
		r = put8(b, SSF_OFF_TYPE, ftype);
		r = put64(r, SSF_OFF_SRC64, o.src64);
		r = put16(r, SSF_OFF_NET16, o.net16);
		r = put8(r, SSF_OFF_RXOPT, opt);
		return r;
	endfunction

	logic        native_ok;
	logic        take;
	ssf_buf_type bld;
	int          p;
	logic [7:0]  flags;
	logic [15:0] adv;

	always_comb begin
		bld        = '0;
		p          = SSF_OFF_TYPE;
		flags      = 8'h00;
		adv        = 16'h0000;
		next_s     = s;
		next_s.drop = 1'b0;
		stage_load = 1'b0;
		stage_byte = 8'h00;
		native_ok  = (api_output_option_in == SSF_AO_NATIVE);
		take       = s.ready && (sensor_valid_in || io_valid_in || node_valid_in);
		case (s.state)
			SSF_IDLE: begin
				// Sensor first, then I/O, then node identification
				if (take && sensor_valid_in) begin
					bld   = put_origin(bld, SSF_TYPE_SENS, sensor_in.origin);
					flags = (sensor_in.ad_read ? SSF_SENS_AD : 8'h00)
					      | (sensor_in.temp_read ? SSF_SENS_TEMP : 8'h00)
					      | (!water_detect_pin_in ? SSF_SENS_WATER : 8'h00);
					bld   = put8(bld, SSF_OFF_SENS, flags);
					for (int c = 0; c < SSF_AD_COUNT; c++) begin
						// Unread channels carry the all-ones fill
						adv = sensor_in.ad_read ? sensor_in.ad[c] : SSF_NO_READING;
						bld = put16(bld, SSF_OFF_AD + 2*c, adv);
					end
					adv = sensor_in.temp_read ? sensor_in.temp : SSF_NO_READING;
					bld = put16(bld, SSF_OFF_TEMP, adv);
					p   = SSF_OFF_S_END;
					if (native_ok) begin
						next_s.frame = bld;
						next_s.len   = 16'(p - SSF_OFF_TYPE);
						next_s.state = SSF_DELIM_S;
					end else begin
						next_s.drop = 1'b1;
					end
				end else if (take && io_valid_in) begin
					bld = put_origin(bld, SSF_TYPE_IO, io_in.origin);
					bld = put8(bld, SSF_OFF_SENS, SSF_ONE_SAMPLE);
					bld = put16(bld, SSF_OFF_AD, io_in.dmask);
					bld = put8(bld, SSF_OFF_AD + 2, io_in.amask);
					p   = SSF_OFF_IO_VAR;
					if (io_in.dmask != 16'h0000) begin
						bld = put16(bld, p, io_in.dsamp & io_in.dmask);
						p   = p + 2;
					end
					for (int c = 0; c < SSF_AD_COUNT; c++) begin
						if (io_in.amask[c]) begin
							bld = put16(bld, p, io_in.analog[c]);
							p   = p + 2;
						end
					end
					if (api_mode_in && native_ok) begin
						next_s.frame = bld;
						next_s.len   = 16'(p - SSF_OFF_TYPE);
						next_s.state = SSF_DELIM_S;
					end else begin
						next_s.drop = 1'b1;
					end
				end else if (take) begin
					bld = put_origin(bld, SSF_TYPE_NODE, node_in.origin);
					p   = SSF_OFF_SENS;
					bld = put16(bld, p, node_in.remote16);
					p   = p + 2;
					bld = put64(bld, p, node_in.remote64);
					p   = p + 8;
					// Name of one character at most; empty name is the terminator alone
					if (node_in.ni_char != SSF_NUL) begin
						bld = put8(bld, p, node_in.ni_char);
						p   = p + 1;
					end
					bld = put8(bld, p, SSF_NUL);
					p   = p + 1;
					bld = put16(bld, p, node_in.parent16);
					p   = p + 2;
					bld = put8(bld, p, node_in.dev_type);
					bld = put8(bld, p + 1, node_in.src_event);
					p   = p + 2;
					bld = put16(bld, p, PROFILE_ID);
					bld = put16(bld, p + 2, MAKER_ID);
					p   = p + 4;
					if (native_ok) begin
						next_s.frame = bld;
						next_s.len   = 16'(p - SSF_OFF_TYPE);
						next_s.state = SSF_DELIM_S;
					end else begin
						next_s.drop = 1'b1;
					end
				end
			end
			SSF_DELIM_S: begin
				if (stage_free) begin
					stage_load   = 1'b1;
					stage_byte   = SSF_DELIM;
					next_s.state = SSF_LEN_HI;
				end
			end
			SSF_LEN_HI: begin
				if (stage_free) begin
					stage_load   = 1'b1;
					stage_byte   = s.len[15:8];
					next_s.state = SSF_LEN_LO;
				end
			end
			SSF_LEN_LO: begin
				if (stage_free) begin
					stage_load   = 1'b1;
					stage_byte   = s.len[7:0];
					next_s.idx   = 16'h0000;
					next_s.csum  = 8'h00;
					next_s.state = SSF_DATA;
				end
			end
			SSF_DATA: begin
				if (stage_free) begin
					stage_load   = 1'b1;
					stage_byte   = s.frame[s.idx];
					next_s.csum  = s.csum + s.frame[s.idx];
					next_s.idx   = s.idx + 16'h0001;
					if (s.idx == s.len - 16'h0001)
						next_s.state = SSF_CSUM;
				end
			end
			SSF_CSUM: begin
				if (stage_free) begin
					stage_load   = 1'b1;
					stage_byte   = SSF_CSUM_BASE - s.csum;
					next_s.state = SSF_IDLE;
				end
			end
			default: begin
				next_s = SSF_CTL_RESET;
			end
		endcase
		// Registered so the ready port is a flop; set from the next state, so no idle cycle is lost per frame
		next_s.ready = (next_s.state == SSF_IDLE);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			s <= SSF_CTL_RESET;
		else
			s <= next_s;
	end

	ssf_out_stage #(
		.WIDTH (8)
	) u_out (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.load_in    (stage_load),
		.data_in    (stage_byte),
		.ready_in   (byte_ready_in),
		.data_out   (byte_out),
		.valid_out  (byte_valid_out),
		.free_out   (stage_free)
	);

	assign req_ready_out = s.ready;
	assign drop_out      = s.drop;

endmodule

// *** hw/ssf_pkg.sv ***
package ssf_pkg;

	// Frame sizing
	localparam int          SSF_MAX_DATA   = 40;
	localparam int          SSF_AD_COUNT   = 4;
	localparam logic [15:0] SSF_LEN_RESET  = 16'h0000;

	// Framing bytes
	localparam logic [7:0]  SSF_DELIM      = 8'h7e;
	localparam logic [7:0]  SSF_CSUM_BASE  = 8'hff;
	localparam logic [7:0]  SSF_TYPE_IO    = 8'h92;
	localparam logic [7:0]  SSF_TYPE_SENS  = 8'h94;
	localparam logic [7:0]  SSF_TYPE_NODE  = 8'h95;
	localparam logic [1:0]  SSF_AO_NATIVE  = 2'h0;

	// Field values
	localparam logic [7:0]  SSF_RX_ACK     = 8'h01;
	localparam logic [7:0]  SSF_RX_BCAST   = 8'h02;
	localparam logic [7:0]  SSF_SENS_AD    = 8'h01;
	localparam logic [7:0]  SSF_SENS_TEMP  = 8'h02;
	localparam logic [7:0]  SSF_SENS_WATER = 8'h60;
	localparam logic [15:0] SSF_NO_READING = 16'hffff;
	localparam logic [7:0]  SSF_ONE_SAMPLE = 8'h01;
	localparam logic [7:0]  SSF_NUL        = 8'h00;

	// Byte offsets within the whole frame; data starts at the type byte
	localparam int          SSF_OFF_TYPE   = 3;
	localparam int          SSF_OFF_SRC64  = 4;
	localparam int          SSF_OFF_NET16  = 12;
	localparam int          SSF_OFF_RXOPT  = 14;
	localparam int          SSF_OFF_SENS   = 15;
	localparam int          SSF_OFF_AD     = 16;
	localparam int          SSF_OFF_TEMP   = 24;
	localparam int          SSF_OFF_S_END  = 26;
	localparam int          SSF_OFF_IO_VAR = 19;

	typedef logic [SSF_MAX_DATA-1:0][7:0] ssf_buf_type;

	typedef struct packed {
		logic [63:0] src64;
		logic [15:0] net16;
		logic        ack;
		logic        bcast;
	} ssf_origin_type;

	typedef struct packed {
		ssf_origin_type                     origin;
		logic                               ad_read;
		logic                               temp_read;
		logic [SSF_AD_COUNT-1:0][15:0]      ad;
		logic [15:0]                        temp;
	} ssf_sensor_type;

	typedef struct packed {
		ssf_origin_type                     origin;
		logic [15:0]                        dmask;
		logic [7:0]                         amask;
		logic [15:0]                        dsamp;
		logic [SSF_AD_COUNT-1:0][15:0]      analog;
	} ssf_io_type;

	typedef struct packed {
		ssf_origin_type                     origin;
		logic [15:0]                        remote16;
		logic [63:0]                        remote64;
		logic [7:0]                         ni_char;
		logic [15:0]                        parent16;
		logic [7:0]                         dev_type;
		logic [7:0]                         src_event;
	} ssf_node_type;

	typedef enum logic [2:0] {
		SSF_IDLE   = 3'b000,
		SSF_DELIM_S= 3'b001,
		SSF_LEN_HI = 3'b011,
		SSF_LEN_LO = 3'b010,
		SSF_DATA   = 3'b110,
		SSF_CSUM   = 3'b111
	} ssf_state_type;

	typedef struct packed {
		ssf_state_type state;
		ssf_buf_type   frame;
		logic [15:0]   len;
		logic [15:0]   idx;
		logic [7:0]    csum;
		logic          ready;
		logic          drop;
	} ssf_ctl_type;

	localparam ssf_ctl_type SSF_CTL_RESET = '{
		state: SSF_IDLE,
		frame: '0,
		len:   SSF_LEN_RESET,
		idx:   SSF_LEN_RESET,
		csum:  8'h00,
		ready: 1'b1,
		drop:  1'b0
	};

endpackage

// *** hw/ssf_out_stage.sv ***
`timescale 1ns/1ps
module ssf_out_stage
	import ssf_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] data_in,
	input  wire logic             ready_in,
	output logic      [WIDTH-1:0] data_out,
	output logic                  valid_out,
	output logic                  free_out
);

	typedef struct packed {
		logic [WIDTH-1:0] data;
		logic             valid;
	} ssf_hold_type;

	ssf_hold_type s;
	ssf_hold_type next_s;

	if (WIDTH < 1) begin : g_width_check
		$error("ssf_out_stage: WIDTH must be at least 1");
	end

	// Free when empty or being drained this cycle, so bytes flow back to back
	assign free_out = !s.valid || ready_in;

	always_comb begin
		next_s = s;
		if (s.valid && ready_in)
			next_s.valid = 1'b0;
		if (load_in && free_out) begin
			next_s.data  = data_in;
			next_s.valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign data_out  = s.data;
	assign valid_out = s.valid;

endmodule

// *** dv/ssf_framer_monitor.sv ***
`timescale 1ns/1ps
module ssf_framer_monitor
	import ssf_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire logic [1:0] api_output_option_in,
	input wire logic       api_mode_in,
	input wire logic       sensor_valid_in,
	input wire logic       io_valid_in,
	input wire logic       node_valid_in,
	input wire logic       req_ready_out,
	input wire logic       drop_out,
	input wire logic [7:0] byte_out,
	input wire logic       byte_valid_out,
	input wire logic       byte_ready_in
);
	logic        take;
	logic        acc;
	logic        last;
	logic        nat;
	logic [5:0]  cnt;
	logic [15:0] len;
	logic [7:0]  sum;
	logic [7:0]  kind;
	assign take = req_ready_out && (sensor_valid_in || io_valid_in || node_valid_in);
	assign acc  = byte_valid_out && byte_ready_in;
	assign nat  = api_output_option_in == SSF_AO_NATIVE;
	// Frame end taken from the length bytes, not from ready, which rises before the checksum is taken
	assign last = acc && cnt >= 6'd3 && {10'd0, cnt} == len + 16'd3;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
			len <= '0;
			sum <= '0;
			kind <= '0;
		end else begin
			if (take && nat)
				kind <= sensor_valid_in ? SSF_TYPE_SENS : io_valid_in ? SSF_TYPE_IO : SSF_TYPE_NODE;
			if (last)
				cnt <= '0;
			else if (acc)
				cnt <= cnt + 6'd1;
			if (acc && cnt == 6'd1)
				len[15:8] <= byte_out;
			if (acc && cnt == 6'd2)
				len[7:0] <= byte_out;
			if (acc && cnt == 6'd2)
				sum <= '0;
			else if (acc && cnt >= 6'd3)
				sum <= sum + byte_out;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_delim_first: assert property (acc && cnt == 6'd0 |-> byte_out == SSF_DELIM) else $error("bad delimiter");
	chk_len_sens: assert property (acc && cnt == 6'd2 && kind == SSF_TYPE_SENS |-> byte_out == 8'h17) else $error("bad length");
	chk_type_byte: assert property (acc && cnt == 6'd3 |-> byte_out == kind) else $error("bad type byte");
	chk_csum_value: assert property (last |-> byte_out == SSF_CSUM_BASE - sum) else $error("bad checksum");
	chk_byte_hold: assert property (byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out)) else $error("byte dropped");
	chk_opt_drop: assert property (take && !nat |=> drop_out && req_ready_out) else $error("option not dropped");
	chk_io_noapi: assert property (take && !sensor_valid_in && io_valid_in && !api_mode_in |=> drop_out) else $error("io kept");
	// Only from an empty stage; a checksum still waiting on the host delays the delimiter
	chk_sens_start: assert property (take && sensor_valid_in && nat && !byte_valid_out |=> !req_ready_out && !drop_out ##1 byte_valid_out && byte_out == SSF_DELIM) else $error("no sensor frame");
	chk_node_start: assert property (take && !sensor_valid_in && !io_valid_in && nat |=> !req_ready_out && !drop_out) else $error("no node frame");
	cover property (take && sensor_valid_in && nat);
	cover property (drop_out);
	cover property (last);
	cover property (take && !sensor_valid_in && io_valid_in && api_mode_in && nat);
	cover property (take && !sensor_valid_in && !io_valid_in && nat);
endmodule
bind ssf_framer ssf_framer_monitor u_mon (.sys_clk_in, .rst_n_in, .api_output_option_in, .api_mode_in, .sensor_valid_in,
	.io_valid_in, .node_valid_in, .req_ready_out, .drop_out, .byte_out, .byte_valid_out, .byte_ready_in);

// *** dv/ssf_host_model.sv ***
`timescale 1ns/1ps
module ssf_host_model (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       slow_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       valid_in,
	output logic            ready_out
);
	logic [7:0] got[$];
	logic [1:0] gap;
	// Slow mode takes one byte in four to stall the framer mid-frame
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_out <= 1'b0;
			gap <= 2'h0;
		end else begin
			if (valid_in && ready_out)
				got.push_back(byte_in);
			gap <= gap + 2'h1;
			ready_out <= !slow_in || gap == 2'h2;
		end
	end
endmodule

// *** dv/sensor_sample_api_framer_tb.sv ***
`timescale 1ns/1ps
module sensor_sample_api_framer_tb;
	import ssf_pkg::*;
	localparam logic [63:0] SRC = 64'h0013a20040522baa;
	logic           clk = 1'b0;
	logic           rst_n = 1'b0;
	logic [1:0]     opt = 2'h0;
	logic           api = 1'b1;
	logic           wet_n = 1'b1;
	logic           slow = 1'b0;
	logic           s_vld = 1'b0;
	logic           i_vld = 1'b0;
	logic           n_vld = 1'b0;
	ssf_sensor_type s_dat = '0;
	ssf_io_type     i_dat = '0;
	ssf_node_type   n_dat = '0;
	logic           rdy;
	logic           drop;
	logic           bvld;
	logic           brdy;
	logic [7:0]     bdat;
	logic [7:0]     exp[$];
	int             bad_count = 0;
	int             n_compared = 0;
	ssf_framer DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .api_output_option_in(opt), .api_mode_in(api),
		.water_detect_pin_in(wet_n), .sensor_valid_in(s_vld), .sensor_in(s_dat), .io_valid_in(i_vld),
		.io_in(i_dat), .node_valid_in(n_vld), .node_in(n_dat), .req_ready_out(rdy), .drop_out(drop),
		.byte_out(bdat), .byte_valid_out(bvld), .byte_ready_in(brdy));
	ssf_host_model host (.sys_clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .byte_in(bdat),
		.valid_in(bvld), .ready_out(brdy));
	initial forever #10 clk = ~clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic put(input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			exp.push_back(v[i*8 +: 8]);
	endtask
	task automatic req(input int k, input logic want_drop);
		@(posedge clk);
		s_vld <= k == 0;
		i_vld <= k == 1;
		n_vld <= k == 2;
		@(posedge clk);
		s_vld <= 1'b0;
		i_vld <= 1'b0;
		n_vld <= 1'b0;
		#1;
		chk({7'h0, drop}, {7'h0, want_drop});
		chk({7'h0, rdy}, {7'h0, want_drop});
	endtask
	task automatic check_frame();
		logic [7:0] sum;
		int         w;
		sum = 8'h00;
		w = 0;
		while (host.got.size() < exp.size() + 4 && w < 400) begin
			@(posedge clk);
			w++;
		end
		// Linger to catch stray bytes after the checksum
		repeat (8) @(posedge clk);
		chk(8'(host.got.size()), 8'(exp.size() + 4));
		chk(host.got[0], SSF_DELIM);
		chk(host.got[1], 8'h00);
		chk(host.got[2], 8'(exp.size()));
		foreach (exp[i]) begin
			chk(host.got[i + 3], exp[i]);
			sum += exp[i];
		end
		chk(host.got[exp.size() + 3], SSF_CSUM_BASE - sum);
		exp.delete();
		host.got.delete();
	endtask
	task automatic t_sensor();
		@(posedge clk);
		slow <= 1'b1;
		s_dat <= '{origin: '{SRC, 16'hdd6c, 1'b1, 1'b0}, ad_read: 1'b1, temp_read: 1'b1,
			ad: {16'h0052, 16'h00ea, 16'h00ce, 16'h0002}, temp: 16'h016a};
		req(0, 1'b0);
		put({SSF_TYPE_SENS, SRC[63:8]}, 8);
		put({SRC[7:0], 16'hdd6c, SSF_RX_ACK, 8'h03}, 5);
		put(64'h0002_00ce_00ea_0052, 8);
		put(16'h016a, 2);
		check_frame();
	endtask
	task automatic t_empty();
		@(posedge clk);
		slow <= 1'b0;
		wet_n <= 1'b0;
		s_dat <= '{origin: '{SRC, 16'h1234, 1'b0, 1'b1}, ad_read: 1'b0, temp_read: 1'b0,
			ad: {4{16'h0101}}, temp: 16'h0202};
		req(0, 1'b0);
		put({SSF_TYPE_SENS, SRC[63:8]}, 8);
		put({SRC[7:0], 16'h1234, SSF_RX_BCAST, SSF_SENS_WATER}, 5);
		put({4{SSF_NO_READING}}, 8);
		put(SSF_NO_READING, 2);
		check_frame();
		wet_n <= 1'b1;
	endtask
	task automatic t_drops();
		for (int o = 1; o < 4; o++)
			for (int k = 0; k < 3; k++) begin
				@(posedge clk);
				opt <= 2'(o);
				req(k, 1'b1);
			end
		@(posedge clk);
		opt <= SSF_AO_NATIVE;
		api <= 1'b0;
		req(1, 1'b1);
		@(posedge clk);
		api <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(host.got.size()), 8'h00);
	endtask
	task automatic t_io();
		@(posedge clk);
		i_dat <= '{origin: '{SRC, 16'h7d84, 1'b1, 1'b0}, dmask: 16'h001c, amask: 8'h02, dsamp: 16'h0f14,
			analog: {16'h0, 16'h0, 16'h0225, 16'h1111}};
		req(1, 1'b0);
		put({SSF_TYPE_IO, SRC[63:8]}, 8);
		put({SRC[7:0], 16'h7d84, SSF_RX_ACK, SSF_ONE_SAMPLE, 16'h001c}, 7);
		put({8'h02, 16'h0014, 16'h0225}, 5);
		check_frame();
	endtask
	task automatic t_node();
		@(posedge clk);
		n_dat <= '{origin: '{SRC, 16'h7d84, 1'b0, 1'b1}, remote16: 16'h7d84, remote64: SRC, ni_char: 8'h20,
			parent16: 16'hfffe, dev_type: 8'h01, src_event: 8'h01};
		req(2, 1'b0);
		put({SSF_TYPE_NODE, SRC[63:8]}, 8);
		put({SRC[7:0], 16'h7d84, SSF_RX_BCAST, 16'h7d84}, 6);
		put(SRC, 8);
		put({8'h20, SSF_NUL, 16'hfffe, 8'h01, 8'h01, 16'h0001}, 8);
		put(16'h0001, 2);
		check_frame();
	endtask
	task automatic t_reset();
		@(posedge clk);
		slow <= 1'b1;
		req(0, 1'b0);
		// Reset lands in the middle of a stalled frame
		repeat (10) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({5'h0, rdy, drop, bvld}, 8'h04);
		@(posedge clk);
		rst_n <= 1'b1;
		slow <= 1'b0;
		@(posedge clk);
		#1;
		chk({5'h0, rdy, drop, bvld}, 8'h04);
		host.got.delete();
	endtask
	task automatic t_io_analog();
		@(posedge clk);
		i_dat <= '{origin: '{SRC, 16'hfffe, 1'b0, 1'b1}, dmask: 16'h0000, amask: 8'h8d, dsamp: 16'hffff,
			analog: {16'h0333, 16'h0222, 16'h0999, 16'h0111}};
		req(1, 1'b0);
		put({SSF_TYPE_IO, SRC[63:8]}, 8);
		put({SRC[7:0], 16'hfffe, SSF_RX_BCAST, SSF_ONE_SAMPLE, 16'h0000}, 7);
		put({8'h8d, 16'h0111, 16'h0222, 16'h0333}, 7);
		check_frame();
	endtask
	task automatic t_node_blank();
		@(posedge clk);
		n_dat <= '{origin: '{SRC, 16'h5678, 1'b1, 1'b1}, remote16: 16'hfffe, remote64: 64'h0123456789abcdef,
			ni_char: SSF_NUL, parent16: 16'h1234, dev_type: 8'h02, src_event: 8'h03};
		req(2, 1'b0);
		put({SSF_TYPE_NODE, SRC[63:8]}, 8);
		put({SRC[7:0], 16'h5678, SSF_RX_ACK | SSF_RX_BCAST, 16'hfffe}, 6);
		put(64'h0123456789abcdef, 8);
		put({SSF_NUL, 16'h1234, 8'h02, 8'h03, 16'h0001}, 7);
		put(16'h0001, 2);
		check_frame();
	endtask
	task automatic t_prio();
		@(posedge clk);
		s_dat <= '{origin: '{SRC, 16'h0abc, 1'b0, 1'b0}, ad_read: 1'b1, temp_read: 1'b0,
			ad: {16'h0444, 16'h0333, 16'h0222, 16'h0111}, temp: 16'h0555};
		s_vld <= 1'b1;
		i_vld <= 1'b1;
		n_vld <= 1'b1;
		@(posedge clk);
		s_vld <= 1'b0;
		i_vld <= 1'b0;
		n_vld <= 1'b0;
		#1;
		chk({6'h0, rdy, drop}, 8'h00);
		put({SSF_TYPE_SENS, SRC[63:8]}, 8);
		put({SRC[7:0], 16'h0abc, 8'h00, SSF_SENS_AD}, 5);
		put(64'h0111_0222_0333_0444, 8);
		put(SSF_NO_READING, 2);
		check_frame();
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({5'h0, rdy, drop, bvld}, 8'h04);
		t_sensor();
		t_empty();
		t_drops();
		t_reset();
		t_io();
		t_io_analog();
		t_node();
		t_node_blank();
		t_prio();
		wrap_up();
	end
endmodule
